// ---- src/lpm_pkg.sv ----
// Package for the low-power mode controller: modes, widths, timing counts.
// Assumes a single 25 MHz system clock.
package lpm_pkg;
  // Clock rate and wakeup timing
  localparam int ClkHz = 25000000;
  localparam int FastWakeNs = 5000;
  localparam int FastWakeCycles = (FastWakeNs * (ClkHz / 1000000)) / 1000;
  localparam int RefSettleNs = 20000;
  localparam int RefSettleCycles = (RefSettleNs * (ClkHz / 1000000)) / 1000;
  localparam int WakeCntW = 10;
  // Source counts
  localparam int ExtIrqCount = 6;
  localparam int PeriphCount = 8;
  localparam int EventCount = 5;
  localparam int HaltWakeCount = 2;
  // Event source bit positions
  localparam int EvtTimerBit = 0;
  localparam int EvtSerialBit = 1;
  localparam int EvtDmaBit = 2;
  localparam int EvtCompBit = 3;
  localparam int EvtPortBit = 4;
  // Power modes
  typedef enum logic [2:0] {
    LPM_RUN = 3'h0,
    LPM_WAIT = 3'h1,
    LPM_LPRUN = 3'h2,
    LPM_LPWAIT = 3'h3,
    LPM_AHALT = 3'h4,
    LPM_HALT = 3'h5,
    LPM_WAKE = 3'h6
  } lpm_mode_type;
endpackage

// ---- src/lpm_wake_timer.sv ----
// Halt wakeup delay counter: one load pulse, then done after the count.
// Assumes single clock mclk and synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module lpm_wake_timer #(
  parameter int CntW = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic load,
  input wire logic [CntW-1:0] loadVal,
  output logic done
);
  logic [CntW-1:0] count_ff;
  logic busy_ff;

  // Down counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_ff <= '0;
      busy_ff <= 1'b0;
    end else if (load) begin
      count_ff <= loadVal;
      busy_ff <= 1'b1;
    end else if (busy_ff && count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end else begin
      busy_ff <= 1'b0;
    end
  end

  // Done when counted out
  assign done = busy_ff && (count_ff == '0);
endmodule
`default_nettype wire

// ---- src/lpm_wake_select.sv ----
// Wakeup source filter: picks which requests may end the present mode.
// Assumes request inputs are synchronous one-cycle or level signals.
`timescale 1ns/10ps
`default_nettype none
module lpm_wake_select (
  // Present mode
  input wire lpm_pkg::lpm_mode_type mode,
  // Sources
  input wire logic intIrq,
  input wire logic [lpm_pkg::ExtIrqCount-1:0] extIrq,
  input wire logic [lpm_pkg::EventCount-1:0] periphEvent,
  input wire logic rtcIrq,
  input wire logic [lpm_pkg::HaltWakeCount-1:0] haltWakeReq,
  // Result
  output logic wake
);
  import lpm_pkg::*;

  // Mode-dependent source gating
  always_comb begin
    wake = 1'b0;
    unique case (mode)
      LPM_WAIT: wake = intIrq || (|extIrq);
      LPM_LPWAIT: wake = |periphEvent;
      LPM_AHALT: wake = rtcIrq || (|extIrq);
      LPM_HALT: wake = (|extIrq) || (|haltWakeReq);
      LPM_RUN, LPM_LPRUN, LPM_WAKE: wake = 1'b0;
      default: wake = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- src/lpm_controller.sv ----
// Low-power mode controller: sequences Run, Wait, Low-power run/wait,
// Active-halt and Halt, and drives clock gates, oscillator, memory and
// regulator controls. Assumes one clock mclk and synchronous reset.
// Function
// - Wait stops the processor clock while selected peripherals keep clocks.
// - Wait is entered on either wait instruction and left on interrupt or reset.
// - Low-power run uses a slow oscillator, RAM fetch, stopped flash/EEPROM, ULP regulator.
// - Low-power run is entered from Run only by software and left by software or reset.
// - A wait-for-event during Low-power run enters Low-power wait with processor stopped.
// - Low-power wait ends on reset or on a timer, serial, DMA, comparator or port event.
// - An event ending Low-power wait returns to Low-power run with the processor clock on.
// - Active-halt stops processor and peripheral clocks except the real-time clock.
// - Active-halt ends on a real-time clock interrupt, external interrupt or reset.
// - Halt stops processor and peripheral clocks, stays powered and keeps RAM.
// - Halt ends on external interrupt, reset, or a halt-capable peripheral request.
// - With fast wakeup chosen, Halt resumes in 5 us without waiting for the reference.
// - Six external interrupt inputs, each its own vector, serve as wakeup sources.
// - Main regulator in Run and Wait; low-power regulator in both halts and LP run/wait.
// - When enabled, the reference voltage is off during Halt.
`timescale 1ns/10ps
`default_nettype none
module lpm_controller #(
  parameter int PeriphN = lpm_pkg::PeriphCount
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Processor requests
  input wire logic waitInterruptInstr,
  input wire logic waitEventInstr,
  input wire logic haltInstr,
  input wire logic activeHaltSel,
  input wire logic lowPowerRunEnter,
  input wire logic lowPowerRunExit,
  // Software configuration
  input wire logic [PeriphN-1:0] periphKeepOn,
  input wire logic fastWakeupEn,
  input wire logic refOffInHaltEn,
  input wire logic useLowSpeedExternal,
  // Wakeup sources
  input wire logic intIrq,
  input wire logic [lpm_pkg::ExtIrqCount-1:0] extIrq,
  input wire logic [lpm_pkg::EventCount-1:0] periphEvent,
  input wire logic rtcIrq,
  input wire logic [lpm_pkg::HaltWakeCount-1:0] haltWakeReq,
  // Clock gating
  output logic cpuClkEn,
  output logic [PeriphN-1:0] periphClkEn,
  output logic rtcClkEn,
  // Oscillator, memory and supply control
  output logic lowSpeedOscSel,
  output logic lowSpeedExtSel,
  output logic fetchFromRam,
  output logic flashEepromOn,
  output logic lowPowerRegulatorMode,
  output logic refVoltageOn,
  output logic ramRetain,
  // Status
  output lpm_pkg::lpm_mode_type powerMode,
  output logic wakePulse
);
  import lpm_pkg::*;

  localparam logic [WakeCntW-1:0] FastLoad = WakeCntW'(FastWakeCycles - 1);
  localparam logic [WakeCntW-1:0] SlowLoad = WakeCntW'(RefSettleCycles - 1);

  lpm_mode_type mode_ff;
  lpm_mode_type nxt_mode;
  logic wake;
  logic timerLoad;
  logic timerDone;
  logic [WakeCntW-1:0] wakeCycles_ff;
  logic refOff_ff;
  logic extSel_ff;
  logic [PeriphN-1:0] gateCfg;

  // Source filter per mode
  lpm_wake_select uSel (
    .mode(mode_ff),
    .intIrq(intIrq),
    .extIrq(extIrq),
    .periphEvent(periphEvent),
    .rtcIrq(rtcIrq),
    .haltWakeReq(haltWakeReq),
    .wake(wake)
  );

  // Halt and Active-halt resume delay
  lpm_wake_timer #(.CntW(WakeCntW)) uTmr (
    .mclk(mclk),
    .reset(reset),
    .load(timerLoad),
    .loadVal((fastWakeupEn || !refOff_ff) ? FastLoad : SlowLoad),
    .done(timerDone)
  );

  // Next mode
  always_comb begin
    nxt_mode = mode_ff;
    timerLoad = 1'b0;
    unique case (mode_ff)
      LPM_RUN: begin
        if (lowPowerRunEnter) begin
          nxt_mode = LPM_LPRUN;
        end else if (haltInstr) begin
          nxt_mode = activeHaltSel ? LPM_AHALT : LPM_HALT;
        end else if (waitInterruptInstr || waitEventInstr) begin
          nxt_mode = LPM_WAIT;
        end
      end
      LPM_WAIT: begin
        if (wake) begin
          nxt_mode = LPM_RUN;
        end
      end
      LPM_LPRUN: begin
        if (lowPowerRunExit) begin
          nxt_mode = LPM_RUN;
        end else if (waitEventInstr) begin
          nxt_mode = LPM_LPWAIT;
        end
      end
      LPM_LPWAIT: begin
        if (wake) begin
          nxt_mode = LPM_LPRUN;
        end
      end
      LPM_AHALT, LPM_HALT: begin
        if (wake) begin
          nxt_mode = LPM_WAKE;
          timerLoad = 1'b1;
        end
      end
      LPM_WAKE: begin
        if (timerDone) begin
          nxt_mode = LPM_RUN;
        end
      end
      default: nxt_mode = LPM_RUN;
    endcase
  end

  // Mode register
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_ff <= LPM_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Captured configuration at mode entry
  always_ff @(posedge mclk) begin
    if (reset) begin
      refOff_ff <= 1'b0;
      extSel_ff <= 1'b0;
    end else if (mode_ff == LPM_RUN) begin
      refOff_ff <= refOffInHaltEn;
      extSel_ff <= useLowSpeedExternal;
    end
  end

  // Wake pulse on entry to Run or Low-power run, except when leaving Low-power run
  always_ff @(posedge mclk) begin
    if (reset) begin
      wakePulse <= 1'b0;
    end else begin
      wakePulse <= (mode_ff != nxt_mode) && (nxt_mode == LPM_RUN || nxt_mode == LPM_LPRUN)
        && (mode_ff != LPM_LPRUN);
    end
  end

  // Cycles spent waking, so the timing check needs no long repetition
  always_ff @(posedge mclk) begin
    if (reset) begin
      wakeCycles_ff <= '0;
    end else if (mode_ff == LPM_WAKE) begin
      wakeCycles_ff <= wakeCycles_ff + 1'b1;
    end else begin
      wakeCycles_ff <= '0;
    end
  end

  // Peripheral gates chosen by software
  assign gateCfg = periphKeepOn;

  // Outputs from the mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpuClkEn <= 1'b1;
      periphClkEn <= '1;
      rtcClkEn <= 1'b1;
      lowSpeedOscSel <= 1'b0;
      lowSpeedExtSel <= 1'b0;
      fetchFromRam <= 1'b0;
      flashEepromOn <= 1'b1;
      lowPowerRegulatorMode <= 1'b0;
      refVoltageOn <= 1'b1;
      ramRetain <= 1'b1;
    end else begin
      ramRetain <= 1'b1;
      lowSpeedExtSel <= extSel_ff;
      refVoltageOn <= !(nxt_mode == LPM_HALT && refOff_ff);
      unique case (nxt_mode)
        LPM_RUN, LPM_WAKE: begin
          cpuClkEn <= (nxt_mode == LPM_RUN);
          periphClkEn <= (nxt_mode == LPM_RUN) ? '1 : '0;
          rtcClkEn <= 1'b1;
          lowSpeedOscSel <= 1'b0;
          fetchFromRam <= 1'b0;
          flashEepromOn <= 1'b1;
          lowPowerRegulatorMode <= (nxt_mode == LPM_WAKE);
        end
        LPM_WAIT: begin
          cpuClkEn <= 1'b0;
          periphClkEn <= gateCfg;
          rtcClkEn <= 1'b1;
          lowSpeedOscSel <= 1'b0;
          fetchFromRam <= 1'b0;
          flashEepromOn <= 1'b1;
          lowPowerRegulatorMode <= 1'b0;
        end
        LPM_LPRUN, LPM_LPWAIT: begin
          cpuClkEn <= (nxt_mode == LPM_LPRUN);
          periphClkEn <= gateCfg;
          rtcClkEn <= 1'b1;
          lowSpeedOscSel <= 1'b1;
          fetchFromRam <= 1'b1;
          flashEepromOn <= 1'b0;
          lowPowerRegulatorMode <= 1'b1;
        end
        LPM_AHALT, LPM_HALT: begin
          cpuClkEn <= 1'b0;
          periphClkEn <= '0;
          rtcClkEn <= (nxt_mode == LPM_AHALT);
          lowSpeedOscSel <= 1'b0;
          fetchFromRam <= 1'b0;
          flashEepromOn <= 1'b0;
          lowPowerRegulatorMode <= 1'b1;
        end
        default: begin
          cpuClkEn <= 1'b1;
          periphClkEn <= '1;
          rtcClkEn <= 1'b1;
          lowSpeedOscSel <= 1'b0;
          fetchFromRam <= 1'b0;
          flashEepromOn <= 1'b1;
          lowPowerRegulatorMode <= 1'b0;
        end
      endcase
    end
  end

  assign powerMode = mode_ff;

  // Wait enters on either instruction
  wait_entry_a: assert property (@(posedge mclk) disable iff (reset)
    mode_ff == LPM_RUN && !lowPowerRunEnter && !haltInstr
      && (waitEventInstr || waitInterruptInstr) |=> mode_ff == LPM_WAIT && !cpuClkEn)
    else $error("wait not entered");

  // Wait processor clock off
  wait_clock_gate_a: assert property (@(posedge mclk) disable iff (reset)
    $past(nxt_mode) == LPM_WAIT && !$past(reset) |-> !cpuClkEn && periphClkEn == $past(gateCfg))
    else $error("wait gating wrong");

  // LP run configuration
  lprun_config_a: assert property (@(posedge mclk) disable iff (reset)
    mode_ff == LPM_LPRUN && $past(mode_ff) == LPM_LPRUN
      |-> lowSpeedOscSel && fetchFromRam && !flashEepromOn && lowPowerRegulatorMode && cpuClkEn)
    else $error("low-power run config wrong");

  // LP run only left by software
  lprun_exit_a: assert property (@(posedge mclk) disable iff (reset)
    mode_ff == LPM_LPRUN && !lowPowerRunExit && !waitEventInstr |=> mode_ff == LPM_LPRUN)
    else $error("low-power run left without request");

  // Event returns LP wait to LP run
  lpwait_event_a: assert property (@(posedge mclk) disable iff (reset)
    mode_ff == LPM_LPWAIT && (|periphEvent) |=> mode_ff == LPM_LPRUN && cpuClkEn)
    else $error("lp wait event return wrong");

  // Interrupts do not end LP wait
  lpwait_irq_a: assert property (@(posedge mclk) disable iff (reset)
    mode_ff == LPM_LPWAIT && !(|periphEvent) |=> mode_ff == LPM_LPWAIT)
    else $error("lp wait left without event");

  // Active-halt keeps only the RTC clock
  ahalt_gate_a: assert property (@(posedge mclk) disable iff (reset)
    mode_ff == LPM_AHALT && $past(mode_ff) == LPM_AHALT
      |-> !cpuClkEn && periphClkEn == '0 && rtcClkEn)
    else $error("active-halt gating wrong");

  // Fast wakeup timing from Halt
  fast_wake_a: assert property (@(posedge mclk) disable iff (reset)
    mode_ff == LPM_HALT && wake && fastWakeupEn |=> mode_ff == LPM_WAKE
      ##125 mode_ff == LPM_RUN && wakeCycles_ff == WakeCntW'(FastWakeCycles))
    else $error("fast wakeup time wrong");

  // Reference off in Halt when enabled
  ref_off_a: assert property (@(posedge mclk) disable iff (reset)
    mode_ff == LPM_HALT && $past(mode_ff) == LPM_HALT && refOff_ff |-> !refVoltageOn)
    else $error("reference not switched off");
endmodule
`default_nettype wire

// ---- testbench/lpm_src_model.sv ----
// Model of the processor requests and wakeup sources that face the controller.
// Assumes the bench names one request bit per command; each pulse lasts one cycle.
`timescale 1ns/10ps
`default_nettype none
module lpm_src_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Bench command and present mode
  input wire logic cmdGo,
  input wire logic [4:0] cmdBit,
  input wire lpm_pkg::lpm_mode_type powerMode,
  // Request pulses, bit map as the bench wires them
  output logic [19:0] reqVec
);
  import lpm_pkg::*;
  logic lpMode;
  // Low-power run and wait, where software keeps interrupts masked
  assign lpMode = (powerMode == LPM_LPRUN) || (powerMode == LPM_LPWAIT);
  // One pulse per command; an interrupt is withheld in Low-power run and wait
  always_ff @(posedge mclk) begin
    if (reset || !cmdGo) begin
      reqVec <= 20'h0;
    end else if (cmdBit == 5'h5 && lpMode) begin
      reqVec <= 20'h0;
    end else begin
      reqVec <= 20'h1 << cmdBit;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the low-power mode controller.
// Assumes lpm_pkg, the controller and the source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lpm_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cmdGo = 1'b0;
  logic [4:0] cmdBit = 5'h0;
  logic ahSel = 1'b0;
  logic [7:0] keep = 8'hff;
  logic fast = 1'b0;
  logic refOff = 1'b0;
  logic low_speed_external_osc = 1'b0;
  logic [19:0] reqVec;
  logic cpuClkEn, rtcClkEn, lowSpeedOscSel, lowSpeedExtSel, fetchFromRam, flashEepromOn;
  logic lowPowerRegulatorMode, refVoltageOn, ramRetain, wakePulse;
  logic [7:0] periphClkEn;
  lpm_mode_type powerMode;
  logic [15:0] rnd = 16'h39b5;
  int errTotal = 0;
  int nTests = 0;
  int cnt;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  // Far side and device
  lpm_src_model u_src (.mclk(mclk), .reset(reset), .cmdGo(cmdGo), .cmdBit(cmdBit),
    .powerMode(powerMode), .reqVec(reqVec));
  lpm_controller u_dut (.mclk(mclk), .reset(reset), .waitInterruptInstr(reqVec[0]),
    .waitEventInstr(reqVec[1]), .haltInstr(reqVec[2]), .activeHaltSel(ahSel),
    .lowPowerRunEnter(reqVec[3]), .lowPowerRunExit(reqVec[4]), .periphKeepOn(keep),
    .fastWakeupEn(fast), .refOffInHaltEn(refOff), .useLowSpeedExternal(low_speed_external_osc),
    .intIrq(reqVec[5]), .extIrq(reqVec[11:6]), .periphEvent(reqVec[16:12]),
    .rtcIrq(reqVec[17]), .haltWakeReq(reqVec[19:18]), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .rtcClkEn(rtcClkEn), .lowSpeedOscSel(lowSpeedOscSel),
    .lowSpeedExtSel(lowSpeedExtSel), .fetchFromRam(fetchFromRam),
    .flashEepromOn(flashEepromOn), .lowPowerRegulatorMode(lowPowerRegulatorMode),
    .refVoltageOn(refVoltageOn), .ramRetain(ramRetain), .powerMode(powerMode),
    .wakePulse(wakePulse));

  // Next pseudo-random value
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Expected {mask, value} of the gating and supply outputs in a mode
  function automatic logic [33:0] expOf(input lpm_mode_type m);
    case (m)
      LPM_RUN: return {9'h1ff, 8'b11111110, 9'h1ff, 8'b10010110};
      LPM_WAIT: return {9'h1ff, 8'b00101010, 1'b0, keep, 8'b00000010};
      LPM_LPRUN, LPM_LPWAIT: return {9'h1ff, 8'b01111011, m == LPM_LPRUN, keep, 7'h35, low_speed_external_osc};
      LPM_AHALT: return {9'h1ff, 8'b10001010, 9'h000, 8'b10001010};
      LPM_HALT: return {9'h1ff, 8'b00001110, 9'h000, 5'b00001, ~refOff, 2'b10};
      default: return 34'h0;
    endcase
  endfunction

  // Report counts and give the verdict
  task automatic wrapUp();
    $display("checks=%0d errors=%0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Mode and the gating outputs selected by the mode's mask against its expectation
  task automatic chkOut(input lpm_mode_type m);
    logic [33:0] e;
    e = expOf(m);
    chk(powerMode, m);
    chk({cpuClkEn, periphClkEn, rtcClkEn, lowSpeedOscSel, fetchFromRam, flashEepromOn,
      lowPowerRegulatorMode, refVoltageOn, ramRetain, lowSpeedExtSel} & e[33:17], e[16:0]);
  endtask

  // One request pulse through the source model
  task automatic req(input int b);
    @(posedge mclk);
    cmdBit <= 5'(b);
    cmdGo <= 1'b1;
    @(posedge mclk);
    cmdGo <= 1'b0;
  endtask

  // Bounded wait for a mode; cnt holds the edges spent
  task automatic waitMode(input lpm_mode_type m, input int lim);
    cnt = 0;
    while (powerMode !== m) begin
      @(posedge mclk);
      #1;
      cnt++;
      if (cnt > lim) begin
        errTotal++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, powerMode, m);
        wrapUp();
      end
    end
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    chkOut(LPM_RUN);
    chk(wakePulse, 1'b0);
    // Each external line ends Wait, entered by both wait instructions
    for (int i = 0; i < ExtIrqCount; i++) begin
      req(i % 2);
      waitMode(LPM_WAIT, 4);
      chkOut(LPM_WAIT);
      req(6 + i);
      waitMode(LPM_RUN, 4);
      chk(wakePulse, 1'b1);
    end
    // Random walk through the modes
    for (int t = 0; t < 24; t++) begin
      rnd = lfsr(rnd);
      @(posedge mclk);
      keep <= rnd[15:8];
      low_speed_external_osc <= rnd[4];
      fast <= rnd[5];
      refOff <= rnd[6];
      ahSel <= (rnd[1:0] == 2'd2);
      case (rnd[1:0])
        2'd0: begin
          req(rnd[2]);
          waitMode(LPM_WAIT, 4);
          chkOut(LPM_WAIT);
          req(rnd[3] ? 5 : 6 + rnd[10:8] % 6);
          waitMode(LPM_RUN, 4);
          chk(wakePulse, 1'b1);
          chkOut(LPM_RUN);
        end
        2'd1: begin
          req(3);
          waitMode(LPM_LPRUN, 4);
          chkOut(LPM_LPRUN);
          req(1);
          waitMode(LPM_LPWAIT, 4);
          chkOut(LPM_LPWAIT);
          req(12 + rnd[11:9] % 5);
          waitMode(LPM_LPRUN, 4);
          chk(wakePulse, 1'b1);
          chkOut(LPM_LPRUN);
          req(4);
          waitMode(LPM_RUN, 4);
          chk(wakePulse, 1'b0);
          chkOut(LPM_RUN);
        end
        2'd2: begin
          req(2);
          waitMode(LPM_AHALT, 4);
          chkOut(LPM_AHALT);
          req(rnd[3] ? 17 : 6 + rnd[10:8] % 6);
          waitMode(LPM_RUN, 600);
          chk(cnt, (fast || !refOff) ? FastWakeCycles + 1 : RefSettleCycles + 1);
          chk(wakePulse, 1'b1);
          chkOut(LPM_RUN);
        end
        default: begin
          req(2);
          waitMode(LPM_HALT, 4);
          chkOut(LPM_HALT);
          req(5);
          repeat (3) @(posedge mclk);
          #1;
          chk(powerMode, LPM_HALT);
          req(rnd[3] ? 18 + rnd[8] : 6 + rnd[10:8] % 6);
          waitMode(LPM_WAKE, 4);
          waitMode(LPM_RUN, 600);
          chk(cnt, (fast || !refOff) ? FastWakeCycles : RefSettleCycles);
          chk(wakePulse, 1'b1);
          chkOut(LPM_RUN);
        end
      endcase
    end
    // Reset in the middle of Low-power wait
    req(3);
    waitMode(LPM_LPRUN, 4);
    req(1);
    waitMode(LPM_LPWAIT, 4);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    chkOut(LPM_RUN);
    chk(wakePulse, 1'b0);
    wrapUp();
  end
endmodule
`default_nettype wire
